// ---- src/cko_clock_ctrl.sv ----
// Purpose: aux clock output, divided-reference outputs, synthesizer pin override, trim
// Assumes: serializer and reference half-period ticks come from logic on clk_i
// Notes: outputs are clock-shaped levels built from tick counters
//
// Notes on behaviour
// - The aux output is idle when its enable bit 7 is 0 and driven when it is 1.
// - A serializer-derived aux output is flagged as a usable receiver reference clock.
// - Aux select 0, 1, 2 give 16, 32, 64 UI clocks, 3 the resampled timestamp, 4-7 reserved.
// - Override bit 7 at 0 means the pins rule the synthesizer, at 1 the soft fields do.
// - Under override the second divided-reference field gives off, /1, /2 or /4.
// - Under override the first divided-reference field gives off, /1, /2 or /4.
// - The second divided-reference output runs only while the first one runs.
// - Without override both divided-reference fields are ignored and the cfg pins decide.
// - Under override bit 1 selects the single-ended synthesizer reference input.
// - Under override bit 0 enables the synthesizer.
// - Trim bit 7 is reserved and reset loads the trim value with 0.
// - The trim in bits 6 to 0 is set by calibration and can be read back.
`timescale 1ns/1ps
module cko_clock_ctrl #(
    parameter int DIV_CNT_W = 3
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sdi_i,
    output logic spi_sdo_o,
    output logic spi_sdo_oe_n_o,
    input wire logic ser_half_tick_i,
    input wire logic ser_reinit_i,
    input wire logic ref_half_tick_i,
    input wire logic timestamp_in_pin_i,
    input wire logic synth_enable_pin_i,
    input wire logic single_ref_select_pin_i,
    input wire logic clock_cfg_pin0_i,
    input wire logic clock_cfg_pin1_i,
    input wire logic oscillator_cal_enable_i,
    input wire logic oscillator_cal_complete_i,
    input wire logic cal_trim_we_i,
    input wire logic [cko_pkg::CKO_TRIM_W-1:0] cal_trim_i,
    output logic aux_out_pin_o,
    output logic receiver_ref_clock_valid_o,
    output logic synth_enable_o,
    output logic single_ref_select_o,
    output logic divref_out_first_o,
    output logic divref_out_second_o,
    output logic [cko_pkg::CKO_TRIM_W-1:0] oscillator_freq_trim_o
);
    import cko_pkg::*;

    initial begin
        if (DIV_CNT_W < 3) begin
            $error("cko_clock_ctrl: DIV_CNT_W must be at least 3 for divide by 64");
        end
    end

    localparam int NPIN = 5;

    logic [7:0] aux_ctrl_q;
    logic [7:0] synth_ovr_q;
    logic [CKO_TRIM_W-1:0] trim_q;
    logic [DIV_CNT_W-1:0] ser_cnt_q;
    logic [DIV_CNT_W-1:0] ref_cnt_q;
    wire [NPIN-1:0] pin_raw;
    wire [NPIN-1:0] pin_sync;
    logic [14:0] bus_addr;
    logic [7:0] bus_wdata;
    logic bus_wr;
    logic [7:0] bus_rdata;

    function automatic logic div_level(input logic [1:0] sel, input logic [DIV_CNT_W-1:0] cnt);
        logic lvl;
        lvl = 1'b0;
        case (sel)
            CKO_DIV_BY1: lvl = cnt[0];
            CKO_DIV_BY2: lvl = cnt[1];
            CKO_DIV_BY4: lvl = cnt[2];
            default: lvl = 1'b0;
        endcase
        return lvl;
    endfunction

    cko_spi_slave #(
        .ADDR_W(15)
    ) u_spi (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .sclk_i(spi_sclk_i),
        .cs_n_i(spi_cs_n_i),
        .sdi_i(spi_sdi_i),
        .sdo_o(spi_sdo_o),
        .sdo_oe_n_o(spi_sdo_oe_n_o),
        .addr_o(bus_addr),
        .wdata_o(bus_wdata),
        .wr_o(bus_wr),
        .rdata_i(bus_rdata)
    );

    // pins are asynchronous; only the second stage is read
    assign pin_raw = {clock_cfg_pin1_i, clock_cfg_pin0_i, single_ref_select_pin_i,
                      synth_enable_pin_i, timestamp_in_pin_i};
    // one process per bit keeps every flop with a single writer
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            logic s0_q;
            logic s1_q;
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    s0_q <= 1'b0;
                    s1_q <= 1'b0;
                end else begin
                    s0_q <= pin_raw[gi];
                    s1_q <= s0_q;
                end
            end
            assign pin_sync[gi] = s1_q;
        end
    endgenerate

    wire tstamp_s = pin_sync[0];
    wire [1:0] cfg_pins = {pin_sync[4], pin_sync[3]};

    wire wr_aux = bus_wr && bus_addr == CKO_AUX_CTRL_ADDR;
    wire wr_ovr = bus_wr && bus_addr == CKO_SYNTH_OVR_ADDR;
    // a write during calibration would fight the engine, which wins
    wire cal_running = oscillator_cal_enable_i && !oscillator_cal_complete_i;
    wire wr_trim = bus_wr && bus_addr == CKO_TRIM_ADDR && !cal_running;

    assign bus_rdata = (bus_addr == CKO_AUX_CTRL_ADDR) ? aux_ctrl_q :
                       (bus_addr == CKO_SYNTH_OVR_ADDR) ? synth_ovr_q :
                       (bus_addr == CKO_TRIM_ADDR) ? {1'b0, trim_q} : 8'h00;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            aux_ctrl_q <= CKO_AUX_CTRL_RST;
            synth_ovr_q <= CKO_SYNTH_OVR_RST;
        end else begin
            // reserved bits are kept at zero whatever is written
            if (wr_aux) begin
                aux_ctrl_q <= bus_wdata & 8'h87;
            end
            if (wr_ovr) begin
                synth_ovr_q <= bus_wdata & 8'hbf;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            trim_q <= CKO_TRIM_RST;
        end else if (cal_trim_we_i) begin
            trim_q <= cal_trim_i;
        end else if (wr_trim) begin
            trim_q <= bus_wdata[CKO_TRIM_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i || ser_reinit_i) begin
            ser_cnt_q <= '0;
        end else if (ser_half_tick_i) begin
            ser_cnt_q <= ser_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ref_cnt_q <= '0;
        end else if (ref_half_tick_i) begin
            ref_cnt_q <= ref_cnt_q + 1'b1;
        end
    end

    wire aux_en = aux_ctrl_q[CKO_AUX_EN_BIT];
    wire [2:0] aux_sel = aux_ctrl_q[CKO_AUX_SEL_LSB +: CKO_AUX_SEL_W];
    wire ovr = synth_ovr_q[CKO_OVR_EN_BIT];

    wire aux_lvl = (aux_sel == CKO_SEL_UI16) ? ser_cnt_q[0] :
                   (aux_sel == CKO_SEL_UI32) ? ser_cnt_q[1] :
                   (aux_sel == CKO_SEL_UI64) ? ser_cnt_q[2] :
                   (aux_sel == CKO_SEL_TSTAMP) ? tstamp_s : 1'b0;
    wire aux_is_ser = aux_sel <= CKO_SEL_UI64;

    // pin mode: cfg pins pick the first, both high adds the second
    wire [1:0] pin_sel1 = cfg_pins;
    wire [1:0] pin_sel2 = (cfg_pins == 2'h3) ? CKO_DIV_BY1 : CKO_DIV_OFF;
    wire [1:0] sel1 = ovr ? synth_ovr_q[CKO_DIV1_LSB +: CKO_DIVSEL_W] : pin_sel1;
    wire [1:0] sel2_raw = ovr ? synth_ovr_q[CKO_DIV2_LSB +: CKO_DIVSEL_W] : pin_sel2;
    wire [1:0] sel2 = (sel1 == CKO_DIV_OFF) ? CKO_DIV_OFF : sel2_raw;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            aux_out_pin_o <= 1'b0;
            receiver_ref_clock_valid_o <= 1'b0;
            synth_enable_o <= 1'b0;
            single_ref_select_o <= 1'b0;
            divref_out_first_o <= 1'b0;
            divref_out_second_o <= 1'b0;
            oscillator_freq_trim_o <= CKO_TRIM_RST;
        end else begin
            aux_out_pin_o <= aux_en & aux_lvl;
            receiver_ref_clock_valid_o <= aux_en & aux_is_ser;
            synth_enable_o <= ovr ? synth_ovr_q[CKO_SYNEN_BIT] : pin_sync[1];
            single_ref_select_o <= ovr ? synth_ovr_q[CKO_REFSEL_BIT] : pin_sync[2];
            divref_out_first_o <= div_level(sel1, ref_cnt_q);
            divref_out_second_o <= div_level(sel2, ref_cnt_q);
            oscillator_freq_trim_o <= trim_q;
        end
    end
endmodule

// ---- src/cko_pkg.sv ----
// Purpose: shared constants for the clock output and synthesizer override block
// Assumes: 8-bit registers reached through a 24-bit serial frame
// Notes: reserved bits are stored as zero and read back as zero
package cko_pkg;
    // register offsets
    localparam logic [14:0] CKO_AUX_CTRL_ADDR = 15'h0057;
    localparam logic [14:0] CKO_SYNTH_OVR_ADDR = 15'h0058;
    localparam logic [14:0] CKO_TRIM_ADDR = 15'h0059;

    // reset values
    localparam logic [7:0] CKO_AUX_CTRL_RST = 8'h00;
    localparam logic [7:0] CKO_SYNTH_OVR_RST = 8'h00;
    localparam logic [6:0] CKO_TRIM_RST = 7'h00;

    // aux_output_control fields
    localparam int CKO_AUX_EN_BIT = 7;
    localparam int CKO_AUX_SEL_LSB = 0;
    localparam int CKO_AUX_SEL_W = 3;

    // synth_pin_override fields
    localparam int CKO_OVR_EN_BIT = 7;
    localparam int CKO_DIV2_LSB = 4;
    localparam int CKO_DIV1_LSB = 2;
    localparam int CKO_DIVSEL_W = 2;
    localparam int CKO_REFSEL_BIT = 1;
    localparam int CKO_SYNEN_BIT = 0;

    // oscillator_trim field
    localparam int CKO_TRIM_W = 7;

    // aux output select codes
    localparam logic [2:0] CKO_SEL_UI16 = 3'h0;
    localparam logic [2:0] CKO_SEL_UI32 = 3'h1;
    localparam logic [2:0] CKO_SEL_UI64 = 3'h2;
    localparam logic [2:0] CKO_SEL_TSTAMP = 3'h3;

    // divided-reference select codes
    localparam logic [1:0] CKO_DIV_OFF = 2'h0;
    localparam logic [1:0] CKO_DIV_BY1 = 2'h1;
    localparam logic [1:0] CKO_DIV_BY2 = 2'h2;
    localparam logic [1:0] CKO_DIV_BY4 = 2'h3;

    // serial frame layout
    localparam logic [4:0] CKO_FRAME_HDR_BITS = 5'h10;
    localparam logic [4:0] CKO_FRAME_BITS = 5'h18;

    // synchroniser depth
    localparam int CKO_SYNC_STAGES = 2;
endpackage

// ---- src/cko_spi_slave.sv ----
// Purpose: serial register port, oversampled by the system clock
// Assumes: mode 0, frame = read flag, 15-bit address, 8-bit data, msb first
// Notes: sclk must stay below a quarter of clk_i for the edge detect to work
`timescale 1ns/1ps
module cko_spi_slave #(
    parameter int ADDR_W = 15
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_n_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    input wire logic [7:0] rdata_i
);
    import cko_pkg::*;

    initial begin
        if (ADDR_W != 15) begin
            $error("cko_spi_slave: frame layout needs ADDR_W of 15");
        end
    end

    logic [2:0] sclk_s_q;
    logic [1:0] cs_s_q;
    logic [1:0] sdi_s_q;
    logic [4:0] cnt_q;
    logic [15:0] in_sh_q;
    logic [7:0] out_sh_q;
    logic rd_q;

    // stage 0 feeds stage 1 only; edges use stages 1 and 2
    wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
    wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
    wire cs_act = ~cs_s_q[1];
    wire hdr_done = sclk_rise && (cnt_q == CKO_FRAME_HDR_BITS - 5'h1);
    wire frame_done = sclk_rise && (cnt_q == CKO_FRAME_BITS - 5'h1);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sclk_s_q <= 3'h0;
            cs_s_q <= 2'h3;
            sdi_s_q <= 2'h0;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], sclk_i};
            cs_s_q <= {cs_s_q[0], cs_n_i};
            sdi_s_q <= {sdi_s_q[0], sdi_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i || !cs_act) begin
            cnt_q <= 5'h0;
            in_sh_q <= 16'h0000;
            wr_o <= 1'b0;
        end else begin
            wr_o <= frame_done && !rd_q;
            if (sclk_rise) begin
                in_sh_q <= {in_sh_q[14:0], sdi_s_q[1]};
                cnt_q <= (cnt_q == CKO_FRAME_BITS - 5'h1) ? 5'h0 : cnt_q + 5'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            addr_o <= '0;
            wdata_o <= 8'h00;
            rd_q <= 1'b0;
        end else if (hdr_done) begin
            rd_q <= in_sh_q[14];
            addr_o <= {in_sh_q[13:0], sdi_s_q[1]};
        end else if (frame_done) begin
            wdata_o <= {in_sh_q[6:0], sdi_s_q[1]};
        end
    end

    // data leaves on falling edges so the host samples it on rising ones
    always_ff @(posedge clk_i) begin
        if (reset_i || !cs_act) begin
            sdo_o <= 1'b0;
            out_sh_q <= 8'h00;
            sdo_oe_n_o <= 1'b1;
        end else if (sclk_fall && rd_q && cnt_q == CKO_FRAME_HDR_BITS) begin
            sdo_o <= rdata_i[7];
            out_sh_q <= {rdata_i[6:0], 1'b0};
            sdo_oe_n_o <= 1'b0;
        end else if (sclk_fall && cnt_q > CKO_FRAME_HDR_BITS) begin
            sdo_o <= out_sh_q[7];
            out_sh_q <= {out_sh_q[6:0], 1'b0};
        end else if (sclk_fall && cnt_q == 5'h0) begin
            sdo_oe_n_o <= 1'b1;
        end
    end
endmodule

// ---- dv/cko_clock_ctrl_checker.sv ----
// Purpose: port-level assertions for the clock output and override block
// Assumes: ticks every 4 clk, straps and cal inputs driven from clk_i
// Notes: idle limits suit the bench tick rate, not every system
`timescale 1ns/1ps
module cko_clock_ctrl_checker (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sdi_i,
    input wire logic spi_sdo_o,
    input wire logic spi_sdo_oe_n_o,
    input wire logic ser_half_tick_i,
    input wire logic ser_reinit_i,
    input wire logic ref_half_tick_i,
    input wire logic timestamp_in_pin_i,
    input wire logic synth_enable_pin_i,
    input wire logic single_ref_select_pin_i,
    input wire logic clock_cfg_pin0_i,
    input wire logic clock_cfg_pin1_i,
    input wire logic oscillator_cal_enable_i,
    input wire logic oscillator_cal_complete_i,
    input wire logic cal_trim_we_i,
    input wire logic [cko_pkg::CKO_TRIM_W-1:0] cal_trim_i,
    input wire logic aux_out_pin_o,
    input wire logic receiver_ref_clock_valid_o,
    input wire logic synth_enable_o,
    input wire logic single_ref_select_o,
    input wire logic divref_out_first_o,
    input wire logic divref_out_second_o,
    input wire logic [cko_pkg::CKO_TRIM_W-1:0] oscillator_freq_trim_o
);
    import cko_pkg::*;
    logic [7:0] cs_idle_q, strap_q, first_q;
    // saturating age counters give the second divided, synthesizer-enable and reference-select checks a bounded cause window
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cs_idle_q <= 8'h00;
            strap_q <= 8'h00;
            first_q <= 8'h00;
        end else begin
            cs_idle_q <= spi_cs_n_i ? cs_idle_q + 8'(cs_idle_q != 8'hff) : 8'h00;
            strap_q <= $changed({synth_enable_pin_i, single_ref_select_pin_i}) ? 8'h00
                : strap_q + 8'(strap_q != 8'hff);
            first_q <= $changed(divref_out_first_o) ? 8'h00 : first_q + 8'(first_q != 8'hff);
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    a_reset_outs: assert property (disable iff (1'b0)
        reset_i |=> !aux_out_pin_o && !receiver_ref_clock_valid_o && !divref_out_first_o
            && !divref_out_second_o && !synth_enable_o && oscillator_freq_trim_o == 7'h00)
        else $error("outputs not idle after reset");
    a_cal_load: assert property (
        cal_trim_we_i |-> ##2 oscillator_freq_trim_o == $past(cal_trim_i, 2))
        else $error("calibration trim not loaded");
    a_second_first: assert property (
        $rose(divref_out_second_o) |-> first_q < 8'h64 || cs_idle_q < 8'h28)
        else $error("second divided output runs while first is idle");
    a_ts_follow: assert property (
        $rose(aux_out_pin_o) && !receiver_ref_clock_valid_o
        |-> $past(timestamp_in_pin_i, 3) || $past(timestamp_in_pin_i, 4))
        else $error("aux rose without timestamp cause");
    a_aux_tick: assert property (
        $changed(aux_out_pin_o) && receiver_ref_clock_valid_o
            && $past(receiver_ref_clock_valid_o, 3)
        |-> $past(ser_half_tick_i) || $past(ser_half_tick_i, 2) || $past(ser_half_tick_i, 3)
            || $past(ser_reinit_i) || $past(ser_reinit_i, 2))
        else $error("aux clock moved without a serializer tick");
    a_reinit_low: assert property (
        ser_reinit_i [*4] ##0 receiver_ref_clock_valid_o |-> !aux_out_pin_o)
        else $error("aux clock not held during serializer restart");
    a_synth_cause: assert property (
        $changed(synth_enable_o) |-> cs_idle_q < 8'h10 || strap_q < 8'h06)
        else $error("synthesizer enable changed without cause");
    a_refsel_cause: assert property (
        $changed(single_ref_select_o) |-> cs_idle_q < 8'h10 || strap_q < 8'h06)
        else $error("reference select changed without cause");
endmodule

// ---- dv/cko_spi_host.sv ----
// Purpose: serial host model issuing one register frame per call
// Assumes: mode 0, 24-bit frame, 12 clk per sclk period
// Notes: sdi flips when deselected so stale data is never reused
`timescale 1ns/1ps
module cko_spi_host (
    input wire logic clk_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd,
        output logic [7:0] q);
        logic [23:0] f;
        f = {rd, a, wd};
        q = 8'h00;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(posedge clk_i);
            sclk_o <= 1'b0;
            sdi_o <= f[i];
            repeat (6) @(posedge clk_i);
            #1;
            if (i < 8) q[i] = sdo_i;
            @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
        repeat (2) @(posedge clk_i);
        sclk_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        cs_n_o <= 1'b1;
        sdi_o <= ~sdi_o;
    endtask
endmodule

// ---- dv/tb_cko_clock_ctrl.sv ----
// Purpose: self-checking bench for the clock output and override block
// Assumes: ticks every 4 clk, timestamp pin toggles every 8 clk
// Notes: clock rates judged by toggle counts over 256 clk windows
`timescale 1ns/1ps
module tb_cko_clock_ctrl;
    import cko_pkg::*;
    logic clk_i = 1'b0, reset_i = 1'b1, spi_sclk_i, spi_cs_n_i, spi_sdi_i, spi_sdo_o;
    logic ser_half_tick_i = 1'b0, ser_reinit_i = 1'b0, ref_half_tick_i = 1'b0;
    logic timestamp_in_pin_i = 1'b0, synth_enable_pin_i = 1'b0, single_ref_select_pin_i = 1'b0;
    logic clock_cfg_pin0_i = 1'b0, clock_cfg_pin1_i = 1'b0, cal_trim_we_i = 1'b0;
    logic oscillator_cal_enable_i = 1'b0, oscillator_cal_complete_i = 1'b0;
    logic [CKO_TRIM_W-1:0] cal_trim_i = 7'h00, oscillator_freq_trim_o;
    logic spi_sdo_oe_n_o, aux_out_pin_o, receiver_ref_clock_valid_o, synth_enable_o;
    logic single_ref_select_o, divref_out_first_o, divref_out_second_o;
    logic [7:0] cnt = 8'h00, rd;
    logic win = 1'b0, clr = 1'b0, p_a, p_1, p_2;
    int n_a, n_1, n_2, fails = 0, num_checks = 0;
    always #5 clk_i = ~clk_i;
    cko_clock_ctrl uut (.*);
    // a released data line reads inverted, so a read without drive enable fails
    cko_spi_host host (.clk_i(clk_i), .sclk_o(spi_sclk_i), .cs_n_o(spi_cs_n_i),
        .sdi_o(spi_sdi_i), .sdo_i(spi_sdo_oe_n_o ? ~spi_sdo_o : spi_sdo_o));
    always @(posedge clk_i) begin
        cnt <= cnt + 8'h01;
        ser_half_tick_i <= cnt[1:0] == 2'h3;
        ref_half_tick_i <= cnt[1:0] == 2'h3;
        timestamp_in_pin_i <= cnt[3];
        p_a <= aux_out_pin_o;
        p_1 <= divref_out_first_o;
        p_2 <= divref_out_second_o;
        n_a <= clr ? 0 : n_a + int'(win && aux_out_pin_o !== p_a);
        n_1 <= clr ? 0 : n_1 + int'(win && divref_out_first_o !== p_1);
        n_2 <= clr ? 0 : n_2 + int'(win && divref_out_second_o !== p_2);
    end
    task automatic final_report;
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, rd);
        repeat (8) @(posedge clk_i);
    endtask
    task automatic rdchk(input logic [14:0] a, input logic [7:0] e);
        host.xfer(1'b1, a, 8'h00, rd);
        chk("rdata", 32'(e), 32'(rd));
    endtask
    // settle, then count output edges over exactly 256 clk
    task automatic measure;
        repeat (40) @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        win <= 1'b1;
        repeat (256) @(posedge clk_i);
        win <= 1'b0;
        @(posedge clk_i);
    endtask
    initial begin
        repeat (100000) @(posedge clk_i);
        fails++;
        final_report;
    end
    initial begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("outs", 32'h0, 32'({aux_out_pin_o, synth_enable_o, oscillator_freq_trim_o}));
        rdchk(CKO_AUX_CTRL_ADDR, CKO_AUX_CTRL_RST);
        rdchk(CKO_SYNTH_OVR_ADDR, CKO_SYNTH_OVR_RST);
        rdchk(CKO_TRIM_ADDR, {1'b0, CKO_TRIM_RST});
        wr(15'h005a, 8'h55);
        rdchk(15'h005a, 8'h00);
        wr(CKO_AUX_CTRL_ADDR, 8'h7f);
        rdchk(CKO_AUX_CTRL_ADDR, 8'h07);
        wr(CKO_AUX_CTRL_ADDR, 8'h87);
        measure;
        chk("aux_rsvd", 32'h0, n_a + 32'(receiver_ref_clock_valid_o));
        wr(CKO_AUX_CTRL_ADDR, 8'h07);
        for (int s = 0; s < 4; s++) begin
            wr(CKO_AUX_CTRL_ADDR, 8'(s));
            measure;
            chk("aux_idle", 32'h0, n_a);
            wr(CKO_AUX_CTRL_ADDR, 8'h80 | 8'(s));
            rdchk(CKO_AUX_CTRL_ADDR, 8'h80 | 8'(s));
            measure;
            chk("aux_toggles", (s == 3) ? 32 : 64 >> s, n_a);
            chk("rx_valid", 32'(s < 3), 32'(receiver_ref_clock_valid_o));
            wr(CKO_AUX_CTRL_ADDR, 8'(s));
        end
        wr(CKO_AUX_CTRL_ADDR, 8'h00);
        wr(CKO_AUX_CTRL_ADDR, 8'h80);
        ser_reinit_i <= 1'b1;
        measure;
        chk("aux_reinit", 32'h0, n_a);
        ser_reinit_i <= 1'b0;
        measure;
        chk("aux_resume", 32'h40, n_a);
        synth_enable_pin_i <= 1'b1;
        single_ref_select_pin_i <= 1'b1;
        wr(CKO_SYNTH_OVR_ADDR, 8'h3c);
        for (int p = 0; p < 4; p++) begin
            {clock_cfg_pin1_i, clock_cfg_pin0_i} <= 2'(p);
            measure;
            chk("first_pin", (p == 0) ? 0 : 64 >> (p - 1), n_1);
            chk("second_pin", (p == 3) ? 64 : 0, n_2);
        end
        chk("pin_mode", 32'h3, {30'h0, synth_enable_o, single_ref_select_o});
        wr(CKO_SYNTH_OVR_ADDR, 8'h81);
        chk("soft_en", 32'h2, {30'h0, synth_enable_o, single_ref_select_o});
        wr(CKO_SYNTH_OVR_ADDR, 8'h82);
        chk("soft_ref", 32'h1, {30'h0, synth_enable_o, single_ref_select_o});
        for (int c = 0; c < 4; c++) begin
            for (int d = 0; d < 4; d++) begin
                wr(CKO_SYNTH_OVR_ADDR, 8'h80 | 8'(d << 4) | 8'(c << 2));
                measure;
                chk("first_soft", (c == 0) ? 0 : 64 >> (c - 1), n_1);
                chk("second_soft", (c == 0 || d == 0) ? 0 : 64 >> (d - 1), n_2);
            end
        end
        wr(CKO_SYNTH_OVR_ADDR, 8'hff);
        rdchk(CKO_SYNTH_OVR_ADDR, 8'hbf);
        cal_trim_i <= 7'h5a;
        cal_trim_we_i <= 1'b1;
        @(posedge clk_i);
        cal_trim_we_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("trim_cal", 32'h5a, 32'(oscillator_freq_trim_o));
        rdchk(CKO_TRIM_ADDR, 8'h5a);
        oscillator_cal_enable_i <= 1'b1;
        // deliberate write while calibrating; it must be dropped
        wr(CKO_TRIM_ADDR, 8'h11);
        oscillator_cal_complete_i <= 1'b1;
        rdchk(CKO_TRIM_ADDR, 8'h5a);
        wr(CKO_TRIM_ADDR, 8'hff);
        rdchk(CKO_TRIM_ADDR, 8'h7f);
        final_report;
    end
endmodule
bind cko_clock_ctrl cko_clock_ctrl_checker chk_i (.*);
